// ==== hdl/tut_defs.vh ====
`ifndef TUT_DEFS_VH
`define TUT_DEFS_VH

// ==========================================================
// Register byte offsets
`define TUT_OFF_CTRL 6'h00
`define TUT_OFF_ADDR_SPACE_IDENT 6'h04
`define TUT_OFF_VPN 6'h08
`define TUT_OFF_LO_EVEN 6'h0c
`define TUT_OFF_LO_ODD 6'h10
`define TUT_OFF_PGSIZE 6'h14
`define TUT_OFF_INDEX 6'h18
`define TUT_OFF_RANDOM 6'h1c
`define TUT_OFF_CMD 6'h20
`define TUT_OFF_STATUS 6'h24

// ==========================================================
// Control register fields
`define TUT_CTRL_KSU_HI 1
`define TUT_CTRL_KSU_LO 0
`define TUT_CTRL_EXL 2
`define TUT_CTRL_ERL 3
`define TUT_CTRL_UX 4
`define TUT_CTRL_SX 5
`define TUT_CTRL_KX 6
`define TUT_CTRL_K0_HI 9
`define TUT_CTRL_K0_LO 7
`define TUT_CTRL_W 10
`define TUT_CTRL_RST 10'h008

// ==========================================================
// Privilege field codes
`define TUT_KSU_KERNEL 2'h0
`define TUT_KSU_SUPER 2'h1
`define TUT_KSU_USER 2'h2

// ==========================================================
// Entry-high fields
`define TUT_ADDR_SPACE_IDENT_W 8
`define TUT_VPN2_W 29
`define TUT_VPN_REGION_HI 30
`define TUT_VPN_REGION_LO 29

// ==========================================================
// Entry-low fields
`define TUT_LO_W 27
`define TUT_LO_PFN_HI 21
`define TUT_LO_PFN_LO 0
`define TUT_LO_CACHE_HI 24
`define TUT_LO_CACHE_LO 22
`define TUT_LO_GLOBAL 25
`define TUT_LO_VALID 26

// ==========================================================
// Page size codes and geometry
`define TUT_PGSIZE_W 3
`define TUT_PGSIZE_MAX 3'h4
`define TUT_PG_MIN_SHIFT 5'd10
`define TUT_PFN_PAD 10'h000

// ==========================================================
// Command and status bits
`define TUT_CMD_WR_INDEXED 0
`define TUT_CMD_WR_RANDOM 1
`define TUT_STAT_SHUTDOWN 0
`define TUT_STAT_HIT_IDX_HI 12
`define TUT_STAT_HIT_IDX_LO 8

// ==========================================================
// Segment and region codes, unmapped kernel windows, random pointer reset
`define TUT_SEG_KCACHED 3'h4
`define TUT_SEG_KUNCACHED 3'h5
`define TUT_SEG_SUPER 3'h6
`define TUT_KCACHED_BASE 32'h8000_0000
`define TUT_KUNCACHED_BASE 32'ha000_0000
`define TUT_UNCACHED_ATTR 3'h2
`define TUT_REGION_USER 2'h0
`define TUT_REGION_SUPER 2'h1
`define TUT_REGION_KERNEL 2'h3
`define TUT_RANDOM_RST 5'h1f

`endif

// ==== hdl/tut_entry.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tut_defs.vh"

module tut_entry
(
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Entry load
  input wire wr_i,
  input wire [`TUT_VPN2_W-1:0] vpn2_i,
  input wire [1:0] region_i,
  input wire [`TUT_ADDR_SPACE_IDENT_W-1:0] addr_space_ident_i,
  input wire [`TUT_PGSIZE_W-1:0] size_i,
  input wire [`TUT_LO_W-1:0] lo_even_i,
  input wire [`TUT_LO_W-1:0] lo_odd_i,
  // Lookup
  input wire [63:0] va_i,
  input wire [`TUT_ADDR_SPACE_IDENT_W-1:0] cur_addr_space_ident_i,
  output wire hit_o,
  output wire [31:0] pa_o,
  output wire [2:0] cache_o
);

  // ==========================================================
  // Stored entry
  reg [`TUT_VPN2_W-1:0] vpn2_r;
  reg [1:0] region_r;
  reg [`TUT_ADDR_SPACE_IDENT_W-1:0] addr_space_ident_r;
  reg [`TUT_PGSIZE_W-1:0] size_r;
  reg [`TUT_LO_W-1:0] lo_even_r;
  reg [`TUT_LO_W-1:0] lo_odd_r;

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      vpn2_r <= {`TUT_VPN2_W{1'b0}};
      region_r <= 2'h0;
      addr_space_ident_r <= {`TUT_ADDR_SPACE_IDENT_W{1'b0}};
      size_r <= {`TUT_PGSIZE_W{1'b0}};
      lo_even_r <= {`TUT_LO_W{1'b0}};
      lo_odd_r <= {`TUT_LO_W{1'b0}};
    end
    else if (wr_i)
    begin
      vpn2_r <= vpn2_i;
      region_r <= region_i;
      addr_space_ident_r <= addr_space_ident_i;
      size_r <= (size_i > `TUT_PGSIZE_MAX) ? `TUT_PGSIZE_MAX : size_i;
      lo_even_r <= lo_even_i;
      lo_odd_r <= lo_odd_i;
    end
  end

  // ==========================================================
  // Compare
  wire [3:0] vpn_shift = {size_r, 1'b0};
  wire [`TUT_VPN2_W-1:0] vpn_mask = {`TUT_VPN2_W{1'b1}} << vpn_shift;
  wire vpn_eq = (((va_i[39:11] ^ vpn2_r) & vpn_mask) == {`TUT_VPN2_W{1'b0}}) &&
    (va_i[63:62] == region_r);
  wire [29:0] va_sh = va_i[39:10] >> vpn_shift;
  wire odd_sel = va_sh[0];
  wire [`TUT_LO_W-1:0] lo_sel = odd_sel ? lo_odd_r : lo_even_r;
  wire global_w = lo_even_r[`TUT_LO_GLOBAL] & lo_odd_r[`TUT_LO_GLOBAL];
  assign hit_o = vpn_eq && (global_w || (addr_space_ident_r == cur_addr_space_ident_i)) &&
    lo_sel[`TUT_LO_VALID];

  // ==========================================================
  // Physical address
  wire [4:0] off_bits = `TUT_PG_MIN_SHIFT + {1'b0, size_r, 1'b0};
  wire [31:0] off_mask = ~({32{1'b1}} << off_bits);
  assign pa_o = ({lo_sel[`TUT_LO_PFN_HI:`TUT_LO_PFN_LO], `TUT_PFN_PAD} & ~off_mask) |
    (va_i[31:0] & off_mask);
  assign cache_o = lo_sel[`TUT_LO_CACHE_HI:`TUT_LO_CACHE_LO];

endmodule
`default_nettype wire

// ==== hdl/tut_xlate.v ====
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tut_defs.vh"

module tut_xlate
#(
  parameter ENTRIES = 32,
  parameter IDX_W = 5
)
(
  // Clock and reset
  input wire SYS_CLK_I,
  input wire RESET_N_I,
  // Register bus
  input wire [5:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output wire [31:0] AVS_READDATA_O,
  output wire AVS_WAITREQUEST_O,
  // Translation request
  input wire REQ_VALID_I,
  input wire [63:0] REQ_VADDR_I,
  output wire REQ_READY_O,
  // Translation result
  output wire RSP_VALID_O,
  output wire RSP_HIT_O,
  output wire [31:0] RSP_PADDR_O,
  output wire [2:0] RSP_CACHE_O,
  output wire RSP_MISS_O,
  output wire RSP_XMISS_O,
  output wire RSP_MULTI_O,
  output wire RSP_ADDR_ERR_O
);

  // ==========================================================
  // Software registers
  reg [`TUT_CTRL_W-1:0] ctrl_r;
  reg [`TUT_ADDR_SPACE_IDENT_W-1:0] addr_space_ident_r;
  reg [`TUT_VPN_REGION_HI:0] vpn_r;
  reg [`TUT_LO_W-1:0] lo_even_r;
  reg [`TUT_LO_W-1:0] lo_odd_r;
  reg [`TUT_PGSIZE_W-1:0] pgsize_r;
  reg [IDX_W-1:0] index_r;
  reg [IDX_W-1:0] random_r;
  reg shutdown_r;
  reg [IDX_W-1:0] last_idx_r;
  reg ack_r;
  reg [31:0] rdata_r;

  // ==========================================================
  // Bus slave, one wait state
  wire bus_req = AVS_READ_I | AVS_WRITE_I;
  wire wr_go = AVS_WRITE_I & ack_r;
  assign AVS_WAITREQUEST_O = bus_req & ~ack_r;
  assign AVS_READDATA_O = rdata_r;
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS_I)
      `TUT_OFF_CTRL: rd_mux[`TUT_CTRL_W-1:0] = ctrl_r;
      `TUT_OFF_ADDR_SPACE_IDENT: rd_mux[`TUT_ADDR_SPACE_IDENT_W-1:0] = addr_space_ident_r;
      `TUT_OFF_VPN: rd_mux[`TUT_VPN_REGION_HI:0] = vpn_r;
      `TUT_OFF_LO_EVEN: rd_mux[`TUT_LO_W-1:0] = lo_even_r;
      `TUT_OFF_LO_ODD: rd_mux[`TUT_LO_W-1:0] = lo_odd_r;
      `TUT_OFF_PGSIZE: rd_mux[`TUT_PGSIZE_W-1:0] = pgsize_r;
      `TUT_OFF_INDEX: rd_mux[IDX_W-1:0] = index_r;
      `TUT_OFF_RANDOM: rd_mux[IDX_W-1:0] = random_r;
      `TUT_OFF_STATUS:
      begin
        rd_mux[`TUT_STAT_SHUTDOWN] = shutdown_r;
        rd_mux[`TUT_STAT_HIT_IDX_HI:`TUT_STAT_HIT_IDX_LO] = last_idx_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // Byte-lane merge of write data into current contents
  wire [31:0] be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
    {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  wire [31:0] wmerge = (rd_mux & ~be_mask) | (AVS_WRITEDATA_I & be_mask);
  wire wr_cmd = wr_go && (AVS_ADDRESS_I == `TUT_OFF_CMD);
  wire cmd_indexed = wr_cmd && be_mask[`TUT_CMD_WR_INDEXED] &&
    AVS_WRITEDATA_I[`TUT_CMD_WR_INDEXED];
  wire cmd_random = wr_cmd && be_mask[`TUT_CMD_WR_RANDOM] &&
    AVS_WRITEDATA_I[`TUT_CMD_WR_RANDOM];
  wire shut_clr = wr_go && (AVS_ADDRESS_I == `TUT_OFF_STATUS) &&
    be_mask[`TUT_STAT_SHUTDOWN] && AVS_WRITEDATA_I[`TUT_STAT_SHUTDOWN];
  always @(posedge SYS_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      ctrl_r <= `TUT_CTRL_RST;
      addr_space_ident_r <= {`TUT_ADDR_SPACE_IDENT_W{1'b0}};
      vpn_r <= {(`TUT_VPN_REGION_HI+1){1'b0}};
      lo_even_r <= {`TUT_LO_W{1'b0}};
      lo_odd_r <= {`TUT_LO_W{1'b0}};
      pgsize_r <= {`TUT_PGSIZE_W{1'b0}};
      index_r <= {IDX_W{1'b0}};
    end
    else
    begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req & ~ack_r)
        rdata_r <= rd_mux;
      if (wr_go)
      begin
        case (AVS_ADDRESS_I)
          `TUT_OFF_CTRL: ctrl_r <= wmerge[`TUT_CTRL_W-1:0];
          `TUT_OFF_ADDR_SPACE_IDENT: addr_space_ident_r <= wmerge[`TUT_ADDR_SPACE_IDENT_W-1:0];
          `TUT_OFF_VPN: vpn_r <= wmerge[`TUT_VPN_REGION_HI:0];
          `TUT_OFF_LO_EVEN: lo_even_r <= wmerge[`TUT_LO_W-1:0];
          `TUT_OFF_LO_ODD: lo_odd_r <= wmerge[`TUT_LO_W-1:0];
          `TUT_OFF_PGSIZE: pgsize_r <= wmerge[`TUT_PGSIZE_W-1:0];
          `TUT_OFF_INDEX: index_r <= wmerge[IDX_W-1:0];
          default: ctrl_r <= ctrl_r;
        endcase
      end
    end
  end

  // ==========================================================
  // Random replacement pointer
  always @(posedge SYS_CLK_I)
  begin
    if (!RESET_N_I)
      random_r <= `TUT_RANDOM_RST;
    else
      random_r <= random_r - {{(IDX_W-1){1'b0}}, 1'b1};
  end

  // ==========================================================
  // Privilege and addressing mode
  wire [1:0] privilege_field = ctrl_r[`TUT_CTRL_KSU_HI:`TUT_CTRL_KSU_LO];
  wire exception_level_flag = ctrl_r[`TUT_CTRL_EXL];
  wire error_level_flag = ctrl_r[`TUT_CTRL_ERL];
  wire [2:0] k0_attr = ctrl_r[`TUT_CTRL_K0_HI:`TUT_CTRL_K0_LO];
  wire mode_user = (privilege_field == `TUT_KSU_USER) && !exception_level_flag && !error_level_flag;
  wire mode_super = (privilege_field == `TUT_KSU_SUPER) && !exception_level_flag && !error_level_flag;
  wire mode_kernel = (privilege_field == `TUT_KSU_KERNEL) || exception_level_flag || error_level_flag;
  wire wide = mode_user ? ctrl_r[`TUT_CTRL_UX] :
    mode_super ? ctrl_r[`TUT_CTRL_SX] : ctrl_r[`TUT_CTRL_KX];

  // Narrow addresses seen as sign-extended 64-bit values
  wire [63:0] va = wide ? REQ_VADDR_I :
    {{32{REQ_VADDR_I[31]}}, REQ_VADDR_I[31:0]};
  wire upper_zero = (va[61:40] == 22'h000000);
  wire compat_hi = (va[63:32] == 32'hffff_ffff);
  wire [2:0] top3 = va[31:29];

  // ==========================================================
  // Segment decode
  reg seg_mapped;
  reg seg_err;
  reg seg_kcached;
  reg seg_kuncached;
  always @*
  begin
    seg_mapped = 1'b0;
    seg_err = 1'b0;
    seg_kcached = 1'b0;
    seg_kuncached = 1'b0;
    if (mode_user)
    begin
      if (!wide)
        seg_err = va[31];
      else
        seg_err = (va[63:40] != 24'h000000);
      seg_mapped = !seg_err;
    end
    else if (mode_super)
    begin
      if (!wide)
        seg_mapped = !va[31] || (top3 == `TUT_SEG_SUPER);
      else
        seg_mapped = ((va[63:62] == `TUT_REGION_USER) && upper_zero) ||
          ((va[63:62] == `TUT_REGION_SUPER) && upper_zero) ||
          (compat_hi && (top3 == `TUT_SEG_SUPER));
      seg_err = !seg_mapped;
    end
    else if (mode_kernel)
    begin
      if (!wide || compat_hi)
      begin
        seg_kcached = va[31] && (top3 == `TUT_SEG_KCACHED);
        seg_kuncached = va[31] && (top3 == `TUT_SEG_KUNCACHED);
        seg_mapped = !seg_kcached && !seg_kuncached;
        seg_err = wide ? 1'b0 : (va[63:32] != {32{va[31]}});
      end
      else
      begin
        seg_mapped = (va[63:62] == `TUT_REGION_USER) && upper_zero;
        seg_err = !seg_mapped;
      end
    end
    else
      seg_err = 1'b1;
  end

  // ==========================================================
  // Entry array and parallel lookup
  wire [ENTRIES-1:0] hit_vec;
  wire [32*ENTRIES-1:0] pa_vec;
  wire [3*ENTRIES-1:0] cache_vec;
  wire [IDX_W-1:0] wr_idx = cmd_random ? random_r : index_r;
  wire [ENTRIES-1:0] wr_vec = {{(ENTRIES-1){1'b0}}, cmd_indexed | cmd_random} << wr_idx;

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1)
    begin : g_ent
      tut_entry u_ent
      (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .wr_i(wr_vec[g]),
        .vpn2_i(vpn_r[`TUT_VPN2_W-1:0]),
        .region_i(vpn_r[`TUT_VPN_REGION_HI:`TUT_VPN_REGION_LO]),
        .addr_space_ident_i(addr_space_ident_r),
        .size_i(pgsize_r),
        .lo_even_i(lo_even_r),
        .lo_odd_i(lo_odd_r),
        .va_i(va),
        .cur_addr_space_ident_i(addr_space_ident_r),
        .hit_o(hit_vec[g]),
        .pa_o(pa_vec[32*g +: 32]),
        .cache_o(cache_vec[3*g +: 3])
      );
    end
  endgenerate
  reg [31:0] hit_pa;
  reg [2:0] hit_cache;
  reg [IDX_W-1:0] hit_idx;
  integer i;
  always @*
  begin
    hit_pa = 32'h0000_0000;
    hit_cache = 3'h0;
    hit_idx = {IDX_W{1'b0}};
    for (i = 0; i < ENTRIES; i = i + 1)
    begin
      if (hit_vec[i])
      begin
        hit_pa = hit_pa | pa_vec[32*i +: 32];
        hit_cache = hit_cache | cache_vec[3*i +: 3];
        hit_idx = i[IDX_W-1:0];
      end
    end
  end
  wire any_hit = |hit_vec;
  wire multi = |(hit_vec & (hit_vec - {{(ENTRIES-1){1'b0}}, 1'b1}));
  wire disabled = shutdown_r | multi;

  // ==========================================================
  // Result stage
  reg rsp_valid_r;
  reg rsp_hit_r;
  reg [31:0] rsp_pa_r;
  reg [2:0] rsp_cache_r;
  reg rsp_miss_r;
  reg rsp_xmiss_r;
  reg rsp_multi_r;
  reg rsp_err_r;
  assign REQ_READY_O = ~rsp_valid_r;
  wire take = REQ_VALID_I & ~rsp_valid_r;
  wire mapped_hit = seg_mapped && any_hit && !disabled;
  wire mapped_miss = seg_mapped && !any_hit && !disabled;
  always @(posedge SYS_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      rsp_valid_r <= 1'b0;
      rsp_hit_r <= 1'b0;
      rsp_pa_r <= 32'h0000_0000;
      rsp_cache_r <= 3'h0;
      rsp_miss_r <= 1'b0;
      rsp_xmiss_r <= 1'b0;
      rsp_multi_r <= 1'b0;
      rsp_err_r <= 1'b0;
      shutdown_r <= 1'b0;
      last_idx_r <= {IDX_W{1'b0}};
    end
    else
    begin
      rsp_valid_r <= take;
      if (take)
      begin
        rsp_err_r <= seg_err;
        rsp_multi_r <= seg_mapped && disabled;
        rsp_hit_r <= !seg_err && (mapped_hit || seg_kcached || seg_kuncached);
        rsp_miss_r <= !seg_err && mapped_miss && !wide;
        rsp_xmiss_r <= !seg_err && mapped_miss && wide;
        if (seg_kcached)
        begin
          rsp_pa_r <= va[31:0] - `TUT_KCACHED_BASE;
          rsp_cache_r <= k0_attr;
        end
        else if (seg_kuncached)
        begin
          rsp_pa_r <= va[31:0] - `TUT_KUNCACHED_BASE;
          rsp_cache_r <= `TUT_UNCACHED_ATTR;
        end
        else if (mapped_hit)
        begin
          rsp_pa_r <= hit_pa;
          rsp_cache_r <= hit_cache;
        end
        else
        begin
          rsp_pa_r <= 32'h0000_0000;
          rsp_cache_r <= 3'h0;
        end
        if (mapped_hit)
          last_idx_r <= hit_idx;
      end
      // Set wins over software clear
      if (take && seg_mapped && !seg_err && multi)
        shutdown_r <= 1'b1;
      else if (shut_clr)
        shutdown_r <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  assign RSP_VALID_O = rsp_valid_r;
  assign RSP_HIT_O = rsp_hit_r;
  assign RSP_PADDR_O = rsp_pa_r;
  assign RSP_CACHE_O = rsp_cache_r;
  assign RSP_MISS_O = rsp_miss_r;
  assign RSP_XMISS_O = rsp_xmiss_r;
  assign RSP_MULTI_O = rsp_multi_r;
  assign RSP_ADDR_ERR_O = rsp_err_r;

endmodule
`default_nettype wire

// ==== testbench/tut_xlate_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tut_defs.vh"

module tut_xlate_asserts
#(
  parameter ENTRIES = 32,
  parameter IDX_W = 5
)
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // Register bus
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // Translation
  input wire logic REQ_VALID_I,
  input wire logic [63:0] REQ_VADDR_I,
  input wire logic REQ_READY_O,
  input wire logic RSP_VALID_O,
  input wire logic RSP_HIT_O,
  input wire logic [31:0] RSP_PADDR_O,
  input wire logic [2:0] RSP_CACHE_O,
  input wire logic RSP_MISS_O,
  input wire logic RSP_XMISS_O,
  input wire logic RSP_MULTI_O,
  input wire logic RSP_ADDR_ERR_O
);
  // ==========================================================
  // Control shadow
  logic [9:0] ctrl_r;
  logic taken;
  logic user;
  logic kern;
  assign taken = REQ_VALID_I && REQ_READY_O;
  assign user = ctrl_r[1:0] == `TUT_KSU_USER && !ctrl_r[2] && !ctrl_r[3];
  assign kern = ctrl_r[1:0] == `TUT_KSU_KERNEL || ctrl_r[2] || ctrl_r[3];
  always @(posedge SYS_CLK_I)
  begin
    if (!RESET_N_I)
      ctrl_r <= `TUT_CTRL_RST;
    else if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `TUT_OFF_CTRL)
    begin
      if (AVS_BYTEENABLE_I[0])
        ctrl_r[7:0] <= AVS_WRITEDATA_I[7:0];
      if (AVS_BYTEENABLE_I[1])
        ctrl_r[9:8] <= AVS_WRITEDATA_I[9:8];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  rsp_after_take_a: assert property (taken |=> RSP_VALID_O)
    else $error("no response after taken request");
  rsp_only_take_a: assert property (!taken |=> !RSP_VALID_O)
    else $error("response without request");
  hit_excl_a: assert property (RSP_VALID_O && RSP_HIT_O |->
    !(RSP_MISS_O || RSP_XMISS_O || RSP_MULTI_O || RSP_ADDR_ERR_O))
    else $error("hit together with error flag");
  nohit_pa_a: assert property (RSP_VALID_O && !RSP_HIT_O |-> RSP_PADDR_O == 32'h0)
    else $error("address without hit");
  user_narrow_err_a: assert property (taken && user && !ctrl_r[4] && REQ_VADDR_I[31]
    |=> RSP_ADDR_ERR_O && !RSP_HIT_O)
    else $error("narrow user top bit not refused");
  user_wide_err_a: assert property (taken && user && ctrl_r[4] && |REQ_VADDR_I[63:40]
    |=> RSP_ADDR_ERR_O && !RSP_HIT_O)
    else $error("wide user high bits not refused");
  narrow_vec_a: assert property (taken && user && !ctrl_r[4] |=> !RSP_XMISS_O)
    else $error("narrow miss on extended vector");
  wide_vec_a: assert property (taken && user && ctrl_r[4] |=> !RSP_MISS_O)
    else $error("wide miss on ordinary vector");
  kcached_a: assert property (taken && kern && !ctrl_r[6]
    && REQ_VADDR_I[63:29] == 35'h7fffffffc |=> RSP_HIT_O
    && RSP_PADDR_O == $past(REQ_VADDR_I[31:0]) - 32'h8000_0000)
    else $error("cached window address wrong");
  kuncached_a: assert property (taken && kern && !ctrl_r[6]
    && REQ_VADDR_I[63:29] == 35'h7fffffffd |=> RSP_HIT_O && RSP_CACHE_O == 3'h2
    && RSP_PADDR_O == $past(REQ_VADDR_I[31:0]) - 32'ha000_0000)
    else $error("uncached window address wrong");
  bus_wait_a: assert property ($rose(AVS_READ_I || AVS_WRITE_I)
    |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("bus wait state wrong");
  cover property (RSP_VALID_O && RSP_HIT_O);
  cover property (RSP_VALID_O && RSP_MULTI_O);
  cover property (RSP_VALID_O && RSP_ADDR_ERR_O);
endmodule

bind tut_xlate tut_xlate_asserts #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_tut_xlate_asserts (
  .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .REQ_VALID_I(REQ_VALID_I),
  .REQ_VADDR_I(REQ_VADDR_I), .REQ_READY_O(REQ_READY_O), .RSP_VALID_O(RSP_VALID_O),
  .RSP_HIT_O(RSP_HIT_O), .RSP_PADDR_O(RSP_PADDR_O), .RSP_CACHE_O(RSP_CACHE_O),
  .RSP_MISS_O(RSP_MISS_O), .RSP_XMISS_O(RSP_XMISS_O), .RSP_MULTI_O(RSP_MULTI_O),
  .RSP_ADDR_ERR_O(RSP_ADDR_ERR_O));
`default_nettype wire

// ==== testbench/tut_pipe_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module tut_pipe_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bench control
  input wire logic start_i,
  input wire logic [63:0] va_i,
  input wire logic [1:0] delay_i,
  output logic busy_o,
  // Request side
  input wire logic rsp_valid_i,
  output logic req_valid_o,
  output logic [63:0] req_vaddr_o
);
  logic pend_r;
  logic [1:0] cnt_r;
  logic [63:0] va_r;
  assign busy_o = pend_r | req_valid_o;
  // ==========================================================
  // Request issue, held until answered
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pend_r <= 1'b0;
      cnt_r <= 2'h0;
      va_r <= 64'h0;
      req_valid_o <= 1'b0;
      req_vaddr_o <= 64'h0;
    end
    else if (req_valid_o)
    begin
      if (rsp_valid_i)
      begin
        req_valid_o <= 1'b0;
        req_vaddr_o <= ~req_vaddr_o;
      end
    end
    else if (pend_r)
    begin
      if (cnt_r == 2'h0)
      begin
        req_valid_o <= 1'b1;
        req_vaddr_o <= va_r;
        pend_r <= 1'b0;
      end
      else
        cnt_r <= cnt_r - 2'h1;
    end
    else if (start_i)
    begin
      pend_r <= 1'b1;
      cnt_r <= delay_i;
      va_r <= va_i;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tut_defs.vh"

module tb;
  typedef struct {logic [9:0] c; logic [63:0] va; logic h; logic [31:0] pa; logic [2:0] ca;
    logic [3:0] fl;} tut_row_t;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, start = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, d;
  logic [63:0] va_s = 64'h0;
  logic [1:0] dly = 2'h0;
  wire logic [31:0] rdata, pa;
  wire logic [63:0] vaddr;
  wire logic [2:0] cache;
  wire logic waitreq, vld, rdy, rvld, hit, miss, xmiss, multi, aerr, busy;
  integer failures = 0, checked = 0;
  tut_row_t rows [0:15];

  always #20 clk = ~clk;
  tut_pipe_model u_tut_pipe_model (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .va_i(va_s),
    .delay_i(dly), .busy_o(busy), .rsp_valid_i(rvld), .req_valid_o(vld), .req_vaddr_o(vaddr));
  tut_xlate u_tut_xlate (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .REQ_VALID_I(vld),
    .REQ_VADDR_I(vaddr), .REQ_READY_O(rdy), .RSP_VALID_O(rvld), .RSP_HIT_O(hit),
    .RSP_PADDR_O(pa), .RSP_CACHE_O(cache), .RSP_MISS_O(miss), .RSP_XMISS_O(xmiss),
    .RSP_MULTI_O(multi), .RSP_ADDR_ERR_O(aerr));

  // ==========================================================
  // Helpers
  task conclude;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input logic we, input logic [5:0] a, input logic [31:0] v);
    integer n;
    begin
      @(posedge clk);
      addr <= a;
      wr <= we;
      rd <= !we;
      wdata <= v;
      n = 0;
      do begin @(posedge clk); n = n + 1; end while (waitreq !== 1'b0 && n < 20);
      d = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 20)
      begin
        failures = failures + 1;
        $display("[FAIL] %0t bus timeout", $time);
        conclude;
      end
    end
  endtask
  task xlate(input logic [63:0] v, input logic [1:0] dl);
    integer n;
    begin
      @(posedge clk);
      start <= 1'b1;
      va_s <= v;
      dly <= dl;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      do begin @(posedge clk); n = n + 1; end while (busy !== 1'b0 && n < 20);
      if (n >= 20)
      begin
        failures = failures + 1;
        $display("[FAIL] %0t translation timeout", $time);
        conclude;
      end
    end
  endtask
  task res(input logic h, input logic [31:0] p, input logic [3:0] f);
    begin
      chk(hit, h);
      chk(pa, p);
      chk({miss, xmiss, multi, aerr}, f);
    end
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    rows[0] = '{10'h002, 64'h4010, 1, 32'h048d1410, 3, 0};
    rows[1] = '{10'h002, 64'h4404, 1, 32'h002af004, 2, 0};
    rows[2] = '{10'h002, 64'h8000_0000, 0, 0, 0, 4'h1};
    rows[3] = '{10'h002, 64'h8000, 0, 0, 0, 4'h8};
    rows[4] = '{10'h012, 64'h1_0000_0000, 0, 0, 0, 4'h4};
    rows[5] = '{10'h012, 64'h100_0000_0000, 0, 0, 0, 4'h1};
    rows[6] = '{10'h012, 64'h4010, 1, 32'h048d1410, 3, 0};
    rows[7] = '{10'h002, 64'h40_1234, 1, 32'h0ff01234, 0, 0};
    rows[8] = '{10'h180, 64'hffff_ffff_8000_1234, 1, 32'h1234, 3, 0};
    rows[9] = '{10'h000, 64'hffff_ffff_a000_0010, 1, 32'h10, 2, 0};
    rows[10] = '{10'h001, 64'h4010, 1, 32'h048d1410, 3, 0};
    rows[11] = '{10'h006, 64'hffff_ffff_8000_0000, 1, 0, 0, 0};
    rows[12] = '{10'h000, 64'h4404, 1, 32'h002af004, 2, 0};
    rows[13] = '{10'h003, 64'h4010, 0, 0, 0, 4'h1};
    rows[14] = '{10'h021, 64'h4000_0000_0000_4010, 0, 0, 0, 4'h4};
    rows[15] = '{10'h040, 64'h4010, 1, 32'h048d1410, 3, 0};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1, `TUT_OFF_CTRL, 0);
    bus(0, `TUT_OFF_CTRL, 0);
    chk(d, 32'h0);
    foreach (rows[k])
    begin
      if (k == 0)
      begin
        bus(1, `TUT_OFF_ADDR_SPACE_IDENT, 32'h77);
        bus(1, `TUT_OFF_VPN, 32'h800);
        bus(1, `TUT_OFF_PGSIZE, 32'h4);
        bus(1, `TUT_OFF_LO_EVEN, 32'h603fc00);
        bus(1, `TUT_OFF_LO_ODD, 32'h6000000);
        bus(1, `TUT_OFF_INDEX, 32'h1);
        bus(1, `TUT_OFF_CMD, 32'h1);
        bus(1, `TUT_OFF_ADDR_SPACE_IDENT, 32'h5);
        bus(1, `TUT_OFF_VPN, 32'h8);
        bus(1, `TUT_OFF_PGSIZE, 32'h0);
        bus(1, `TUT_OFF_LO_EVEN, 32'h4c12345);
        bus(1, `TUT_OFF_LO_ODD, 32'h4800abc);
        bus(1, `TUT_OFF_INDEX, 32'h0);
        bus(1, `TUT_OFF_CMD, 32'h1);
      end
      bus(1, `TUT_OFF_CTRL, {22'h0, rows[k].c});
      xlate(rows[k].va, k[1:0]);
      res(rows[k].h, rows[k].pa, rows[k].fl);
      if (rows[k].h)
        chk(cache, rows[k].ca);
    end
    bus(1, `TUT_OFF_ADDR_SPACE_IDENT, 32'h6);
    bus(1, `TUT_OFF_CTRL, 32'h2);
    xlate(64'h4010, 0);
    res(0, 0, 4'h8);
    bus(1, `TUT_OFF_ADDR_SPACE_IDENT, 32'h5);
    bus(1, `TUT_OFF_INDEX, 32'h2);
    bus(1, `TUT_OFF_CMD, 32'h1);
    xlate(64'h4010, 1);
    res(0, 0, 4'h2);
    bus(0, `TUT_OFF_STATUS, 0);
    chk(d[0], 1'b1);
    xlate(64'h40_1234, 0);
    res(0, 0, 4'h2);
    bus(1, `TUT_OFF_VPN, 32'h100);
    bus(1, `TUT_OFF_CMD, 32'h1);
    bus(1, `TUT_OFF_STATUS, 32'h1);
    bus(0, `TUT_OFF_STATUS, 0);
    chk(d[0], 1'b0);
    bus(1, `TUT_OFF_VPN, 32'h20);
    bus(1, `TUT_OFF_CMD, 32'h2);
    xlate(64'h1_0010, 3);
    res(1, 32'h048d1410, 0);
    bus(1, 6'h3c, 32'hffff_ffff);
    bus(0, 6'h3c, 0);
    chk(d, 32'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({rdy, rvld, hit, miss, multi, aerr}, 6'h20);
    bus(0, `TUT_OFF_CTRL, 0);
    chk(d, 32'h8);
    conclude;
  end
endmodule
`default_nettype wire
